// [core/jnp_engine.sv]
`timescale 1ns/1ps
module jnp_engine #(
  parameter int unsigned FLASH_AW      = 8,
  parameter int unsigned EE_AW         = 8,
  parameter int unsigned TOUT0_CYC     = jnp_pkg::RST_TOUT0_CYC,
  parameter int unsigned TOUT1_CYC     = jnp_pkg::RST_TOUT1_CYC,
  parameter int unsigned TOUT2_CYC     = jnp_pkg::RST_TOUT2_CYC,
  parameter int unsigned TOUT3_CYC     = jnp_pkg::RST_TOUT3_CYC,
  parameter int unsigned PAGE_WR_CYC   = jnp_pkg::PAGE_WR_CYC,
  parameter int unsigned EE_WR_CYC     = jnp_pkg::EE_WR_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // test access pins
  input  wire logic       tck,
  input  wire logic       tms,
  input  wire logic       tdi,
  output logic            tdo,
  output logic            tdo_oe,
  // clock-option configuration bits
  input  wire logic [1:0] clk_opt,
  // status toward the part
  output logic            part_reset,
  output logic            prog_mode,
  output logic            nvm_busy
);

  localparam int unsigned CW = jnp_pkg::CNT_W;

  typedef struct packed {
    jnp_pkg::jnp_tap_t     tap;
    logic [3:0]            ir;
    logic [3:0]            ir_sr;
    logic                  tck_d;
    logic                  bypass;
    logic                  rst_chain;
    logic [15:0]           unlock_sr;
    logic [15:0]           unlock;
    logic                  prog_en;
    logic [14:0]           cmd_sr;
    logic [14:0]           applied;
    logic                  pending;
    logic [7:0]            mode;
    logic [15:0]           addr;
    logic [15:0]           wdata;
    logic                  hi_next;
    logic                  erasing;
    logic [CW-1:0]         busy_cnt;
    logic [CW-1:0]         tout_cnt;
    logic                  part_reset;
    logic                  tdo;
    logic                  tdo_oe;
    logic                  busy;
  } jnp_state_t;

  jnp_state_t          st_ff;
  jnp_state_t          nxt_st;

  logic [2:0]          pins;
  logic [1:0]          opt;
  logic                tck_s;
  logic                tms_s;
  logic                tdi_s;
  logic                tck_re;
  logic                tck_fe;
  logic [6:0]          field;
  logic [7:0]          dbyte;
  logic [14:0]         result;
  logic                busy_now;
  logic                dr_lsb;
  logic [CW-1:0]       tout_load;
  logic                flash_we;
  logic [FLASH_AW-1:0] flash_waddr;
  logic [15:0]         flash_wdata;
  logic [15:0]         flash_rd;
  logic                ee_we;
  logic [7:0]          ee_rd;

  jnp_sync #(
    .W (3)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     ({tck, tms, tdi}),
    .dout    (pins)
  );

  jnp_sync #(
    .W (2)
  ) u_opt_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (clk_opt),
    .dout    (opt)
  );

  jnp_mem #(
    .DATA_W (16),
    .ADDR_W (FLASH_AW)
  ) u_flash (
    .clk_sys (clk_sys),
    .we      (flash_we),
    .waddr   (flash_waddr),
    .wdata   (flash_wdata),
    .raddr   (st_ff.addr[FLASH_AW-1:0]),
    .rdata   (flash_rd)
  );

  jnp_mem #(
    .DATA_W (8),
    .ADDR_W (EE_AW)
  ) u_eeprom (
    .clk_sys (clk_sys),
    .we      (ee_we),
    .waddr   (st_ff.addr[EE_AW-1:0]),
    .wdata   (st_ff.wdata[7:0]),
    .raddr   (st_ff.addr[EE_AW-1:0]),
    .rdata   (ee_rd)
  );

  assign tck_s  = pins[2];
  assign tms_s  = pins[1];
  assign tdi_s  = pins[0];
  assign tck_re = tck_s & ~st_ff.tck_d;
  assign tck_fe = ~tck_s & st_ff.tck_d;

  assign tdo        = st_ff.tdo;
  assign tdo_oe     = st_ff.tdo_oe;
  assign part_reset = st_ff.part_reset;
  assign prog_mode  = st_ff.prog_en;
  assign nvm_busy   = st_ff.busy;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tck_d = tck_s;
    flash_we    = 1'b0;
    flash_waddr = st_ff.addr[FLASH_AW-1:0];
    flash_wdata = st_ff.wdata;
    ee_we       = 1'b0;
    field       = st_ff.cmd_sr[14:8];
    dbyte       = st_ff.cmd_sr[7:0];
    busy_now    = st_ff.erasing | (st_ff.busy_cnt != '0);
    result      = '0;
    dr_lsb      = st_ff.bypass;
    case (opt)
      2'd0:    tout_load = CW'(TOUT0_CYC);
      2'd1:    tout_load = CW'(TOUT1_CYC);
      2'd2:    tout_load = CW'(TOUT2_CYC);
      default: tout_load = CW'(TOUT3_CYC);
    endcase

    // answer of the last applied command, read back at the next capture
    result[jnp_pkg::DONE_BIT] = ~busy_now;
    case (st_ff.mode)
      jnp_pkg::MODE_FLASH_RD: begin
        if (st_ff.applied[14:8] == jnp_pkg::CF_RD_LOW) begin
          result[7:0] = flash_rd[7:0];
        end else if (st_ff.applied[14:8] == jnp_pkg::CF_STROBE_B) begin
          result[7:0] = flash_rd[15:8];
        end
      end
      jnp_pkg::MODE_EE_RD: begin
        if (st_ff.applied[14:8] == jnp_pkg::CF_STROBE_A) begin
          result[7:0] = ee_rd;
        end
      end
      default: begin
      end
    endcase

    case (st_ff.ir)
      jnp_pkg::INSTR_PART_RESET: dr_lsb = st_ff.rst_chain;
      jnp_pkg::INSTR_UNLOCK:     dr_lsb = st_ff.unlock_sr[0];
      jnp_pkg::INSTR_CMD:        dr_lsb = st_ff.cmd_sr[0];
      jnp_pkg::INSTR_PAGEREAD:   dr_lsb = st_ff.cmd_sr[0];
      default:                   dr_lsb = st_ff.bypass;
    endcase

    // background write timer and erase sweep
    if (st_ff.erasing) begin
      flash_we    = 1'b1;
      flash_waddr = st_ff.busy_cnt[FLASH_AW-1:0];
      flash_wdata = '1;
      if (st_ff.busy_cnt[FLASH_AW-1:0] == '1) begin
        nxt_st.erasing  = 1'b0;
        nxt_st.busy_cnt = '0;
      end else begin
        nxt_st.busy_cnt = st_ff.busy_cnt + CW'(1);
      end
    end else if (st_ff.busy_cnt != '0) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - CW'(1);
    end

    if (tck_re) begin
      case (st_ff.tap)
        jnp_pkg::TLR:    nxt_st.tap = tms_s ? jnp_pkg::TLR    : jnp_pkg::RTI;
        jnp_pkg::RTI:    nxt_st.tap = tms_s ? jnp_pkg::SEL_DR : jnp_pkg::RTI;
        jnp_pkg::SEL_DR: nxt_st.tap = tms_s ? jnp_pkg::SEL_IR : jnp_pkg::CAP_DR;
        jnp_pkg::CAP_DR: nxt_st.tap = tms_s ? jnp_pkg::EX1_DR : jnp_pkg::SH_DR;
        jnp_pkg::SH_DR:  nxt_st.tap = tms_s ? jnp_pkg::EX1_DR : jnp_pkg::SH_DR;
        jnp_pkg::EX1_DR: nxt_st.tap = tms_s ? jnp_pkg::UPD_DR : jnp_pkg::PA_DR;
        jnp_pkg::PA_DR:  nxt_st.tap = tms_s ? jnp_pkg::EX2_DR : jnp_pkg::PA_DR;
        jnp_pkg::EX2_DR: nxt_st.tap = tms_s ? jnp_pkg::UPD_DR : jnp_pkg::SH_DR;
        jnp_pkg::UPD_DR: nxt_st.tap = tms_s ? jnp_pkg::SEL_DR : jnp_pkg::RTI;
        jnp_pkg::SEL_IR: nxt_st.tap = tms_s ? jnp_pkg::TLR    : jnp_pkg::CAP_IR;
        jnp_pkg::CAP_IR: nxt_st.tap = tms_s ? jnp_pkg::EX1_IR : jnp_pkg::SH_IR;
        jnp_pkg::SH_IR:  nxt_st.tap = tms_s ? jnp_pkg::EX1_IR : jnp_pkg::SH_IR;
        jnp_pkg::EX1_IR: nxt_st.tap = tms_s ? jnp_pkg::UPD_IR : jnp_pkg::PA_IR;
        jnp_pkg::PA_IR:  nxt_st.tap = tms_s ? jnp_pkg::EX2_IR : jnp_pkg::PA_IR;
        jnp_pkg::EX2_IR: nxt_st.tap = tms_s ? jnp_pkg::UPD_IR : jnp_pkg::SH_IR;
        jnp_pkg::UPD_IR: nxt_st.tap = tms_s ? jnp_pkg::SEL_DR : jnp_pkg::RTI;
        default:         nxt_st.tap = jnp_pkg::TLR;
      endcase

      case (st_ff.tap)
        jnp_pkg::TLR: begin
          nxt_st.ir = jnp_pkg::INSTR_BYPASS;
        end
        jnp_pkg::CAP_IR: begin
          nxt_st.ir_sr = jnp_pkg::IR_CAPTURE_VAL;
        end
        jnp_pkg::SH_IR: begin
          nxt_st.ir_sr = {tdi_s, st_ff.ir_sr[3:1]};
        end
        jnp_pkg::UPD_IR: begin
          nxt_st.ir      = st_ff.ir_sr;
          nxt_st.hi_next = 1'b0;
        end
        jnp_pkg::CAP_DR: begin
          if (st_ff.ir == jnp_pkg::INSTR_CMD && st_ff.prog_en) begin
            nxt_st.cmd_sr = result;
          end else if (st_ff.ir == jnp_pkg::INSTR_PAGEREAD && st_ff.prog_en) begin
            nxt_st.cmd_sr[7:0] = st_ff.hi_next ? flash_rd[15:8] : flash_rd[7:0];
            nxt_st.hi_next     = ~st_ff.hi_next;
            if (st_ff.hi_next) begin
              nxt_st.addr = st_ff.addr + 16'h0001;
            end
          end else if (st_ff.ir == jnp_pkg::INSTR_BYPASS) begin
            nxt_st.bypass = 1'b0;
          end
        end
        jnp_pkg::SH_DR: begin
          case (st_ff.ir)
            jnp_pkg::INSTR_PART_RESET: nxt_st.rst_chain = tdi_s;
            jnp_pkg::INSTR_UNLOCK:     nxt_st.unlock_sr = {tdi_s, st_ff.unlock_sr[15:1]};
            jnp_pkg::INSTR_CMD:        nxt_st.cmd_sr = {tdi_s, st_ff.cmd_sr[14:1]};
            jnp_pkg::INSTR_PAGEREAD:   nxt_st.cmd_sr[7:0] = {tdi_s, st_ff.cmd_sr[7:1]};
            default:                   nxt_st.bypass = tdi_s;
          endcase
        end
        jnp_pkg::UPD_DR: begin
          if (st_ff.ir == jnp_pkg::INSTR_UNLOCK) begin
            nxt_st.unlock  = st_ff.unlock_sr;
            nxt_st.prog_en = (st_ff.unlock_sr == jnp_pkg::UNLOCK_SIG);
          end else if (st_ff.ir == jnp_pkg::INSTR_CMD && st_ff.prog_en) begin
            nxt_st.applied = st_ff.cmd_sr;
            nxt_st.pending = 1'b1;
            case (field)
              jnp_pkg::CF_ENTER:   nxt_st.mode = dbyte;
              jnp_pkg::CF_ADDR_HI: nxt_st.addr[15:8] = dbyte;
              jnp_pkg::CF_ADDR_LO: nxt_st.addr[7:0] = dbyte;
              jnp_pkg::CF_DATA_LO: nxt_st.wdata[7:0] = dbyte;
              jnp_pkg::CF_DATA_HI: nxt_st.wdata[15:8] = dbyte;
              default: begin
              end
            endcase
          end
        end
        jnp_pkg::RTI: begin
          // one internal clock executes the applied command, once
          if (st_ff.pending && st_ff.prog_en) begin
            nxt_st.pending = 1'b0;
            case (st_ff.mode)
              jnp_pkg::MODE_ERASE: begin
                if (st_ff.applied[14:8] == jnp_pkg::CF_STROBE_A_LO && !busy_now) begin
                  nxt_st.erasing  = 1'b1;
                  nxt_st.busy_cnt = '0;
                end
              end
              jnp_pkg::MODE_FLASH_WR: begin
                if (st_ff.applied[14:8] == jnp_pkg::CF_LATCH && !busy_now) begin
                  flash_we = 1'b1;
                end else if (st_ff.applied[14:8] == jnp_pkg::CF_STROBE_B_LO && !busy_now) begin
                  nxt_st.busy_cnt = CW'(PAGE_WR_CYC);
                end
              end
              jnp_pkg::MODE_EE_WR: begin
                if (st_ff.applied[14:8] == jnp_pkg::CF_LATCH && !busy_now) begin
                  ee_we = 1'b1;
                end else if (st_ff.applied[14:8] == jnp_pkg::CF_STROBE_A_LO && !busy_now) begin
                  nxt_st.busy_cnt = CW'(EE_WR_CYC);
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end

    // tdo changes on the falling edge so the programmer samples it on the rising one
    if (tck_fe) begin
      nxt_st.tdo_oe = (st_ff.tap == jnp_pkg::SH_DR) | (st_ff.tap == jnp_pkg::SH_IR);
      nxt_st.tdo    = (st_ff.tap == jnp_pkg::SH_IR) ? st_ff.ir_sr[0] : dr_lsb;
    end

    // chain holds the counter loaded; the time-out runs only once it clears
    if (nxt_st.rst_chain) begin
      nxt_st.tout_cnt = tout_load;
    end else if (st_ff.tout_cnt != '0) begin
      nxt_st.tout_cnt = st_ff.tout_cnt - CW'(1);
    end
    nxt_st.part_reset = nxt_st.rst_chain | (st_ff.tout_cnt > CW'(1));
    nxt_st.busy       = nxt_st.erasing | (nxt_st.busy_cnt != '0);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff           <= '0;
      st_ff.tap       <= jnp_pkg::TLR;
      st_ff.ir        <= jnp_pkg::INSTR_BYPASS;
      st_ff.unlock    <= jnp_pkg::UNLOCK_RST;
      st_ff.unlock_sr <= jnp_pkg::UNLOCK_RST;
      st_ff.mode      <= jnp_pkg::MODE_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// [core/jnp_pkg.sv]
package jnp_pkg;

  // instruction register
  localparam int unsigned  IR_W              = 4;
  localparam logic [3:0]   INSTR_UNLOCK      = 4'h4;
  localparam logic [3:0]   INSTR_CMD         = 4'h5;
  localparam logic [3:0]   INSTR_PAGEREAD    = 4'h7;
  localparam logic [3:0]   INSTR_PART_RESET  = 4'hc;
  localparam logic [3:0]   INSTR_BYPASS      = 4'hf;
  localparam logic [3:0]   IR_CAPTURE_VAL    = 4'h1;

  // data register layout
  localparam int unsigned  CMD_W             = 15;
  localparam int unsigned  BYTE_W            = 8;
  localparam int unsigned  FIELD_W           = 7;
  localparam int unsigned  FIELD_LSB         = 8;
  localparam int unsigned  DONE_BIT          = 9;
  localparam int unsigned  UNLOCK_W          = 16;
  localparam logic [15:0]  UNLOCK_SIG        = 16'ha370;
  localparam logic [15:0]  UNLOCK_RST        = 16'h0000;

  // command fields, upper seven bits of a command word
  localparam logic [6:0]   CF_ENTER          = 7'h23;
  localparam logic [6:0]   CF_ADDR_HI        = 7'h07;
  localparam logic [6:0]   CF_ADDR_LO        = 7'h03;
  localparam logic [6:0]   CF_DATA_LO        = 7'h13;
  localparam logic [6:0]   CF_DATA_HI        = 7'h17;
  localparam logic [6:0]   CF_STROBE_A       = 7'h33;
  localparam logic [6:0]   CF_STROBE_A_LO    = 7'h31;
  localparam logic [6:0]   CF_STROBE_B       = 7'h37;
  localparam logic [6:0]   CF_STROBE_B_LO    = 7'h35;
  localparam logic [6:0]   CF_LATCH          = 7'h77;
  localparam logic [6:0]   CF_RD_ARM         = 7'h32;
  localparam logic [6:0]   CF_RD_LOW         = 7'h36;

  // mode bytes carried by the enter command
  localparam logic [7:0]   MODE_NONE         = 8'h00;
  localparam logic [7:0]   MODE_ERASE        = 8'h80;
  localparam logic [7:0]   MODE_FLASH_WR     = 8'h10;
  localparam logic [7:0]   MODE_FLASH_RD     = 8'h02;
  localparam logic [7:0]   MODE_EE_WR        = 8'h11;
  localparam logic [7:0]   MODE_EE_RD        = 8'h03;

  // timing
  localparam int unsigned  SYS_CLK_MHZ       = 200;
  localparam int unsigned  CNT_W             = 24;
  localparam int unsigned  RST_TOUT0_US      = 1;
  localparam int unsigned  RST_TOUT1_US      = 100;
  localparam int unsigned  RST_TOUT2_US      = 4100;
  localparam int unsigned  RST_TOUT3_US      = 65000;
  localparam int unsigned  PAGE_WR_US        = 4500;
  localparam int unsigned  EE_WR_US          = 3600;
  localparam int unsigned  RST_TOUT0_CYC     = RST_TOUT0_US * SYS_CLK_MHZ;
  localparam int unsigned  RST_TOUT1_CYC     = RST_TOUT1_US * SYS_CLK_MHZ;
  localparam int unsigned  RST_TOUT2_CYC     = RST_TOUT2_US * SYS_CLK_MHZ;
  localparam int unsigned  RST_TOUT3_CYC     = RST_TOUT3_US * SYS_CLK_MHZ;
  localparam int unsigned  PAGE_WR_CYC       = PAGE_WR_US * SYS_CLK_MHZ;
  localparam int unsigned  EE_WR_CYC         = EE_WR_US * SYS_CLK_MHZ;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jnp_tap_t;

endpackage

// [core/jnp_sync.sv]
`timescale 1ns/1ps
// three-stage synchroniser; a bit only changes once stages two and three agree
module jnp_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // level in and filtered level out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] agree;

  assign agree = ~(s2_ff ^ s3_ff);
  assign dout  = out_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= (s3_ff & agree) | (out_ff & ~agree);
    end
  end

endmodule

// [core/jnp_mem.sv]
`timescale 1ns/1ps
// single write port, registered read port
module jnp_mem #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned ADDR_W = 8
) (
  // clock
  input  wire logic              clk_sys,
  // write port
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  // read port
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem_ff [2**ADDR_W];
  logic [DATA_W-1:0] rdata_ff;

  assign rdata = rdata_ff;

  // no reset on the array: contents survive like real cells
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata_ff <= mem_ff[raddr];
  end

endmodule

// [verif/jnp_monitor.sv]
`timescale 1ns/1ps
module jnp_monitor #(
  parameter int unsigned TOUT0_CYC = jnp_pkg::RST_TOUT0_CYC
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  // test pins
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdi,
  input wire logic       tdo,
  input wire logic       tdo_oe,
  // part side
  input wire logic [1:0] clk_opt,
  input wire logic       part_reset,
  input wire logic       prog_mode,
  input wire logic       nvm_busy
);
  // cycles since the last tck rise, saturating; the chain is released on a rise
  logic [15:0] rise_gap_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rise_gap_ff <= 16'h0000;
    end else begin
      rise_gap_ff <= $rose(tck) ? 16'h0000 : rise_gap_ff + 16'(rise_gap_ff != 16'hffff);
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  tdo_steady_a: assert property (tck |-> $stable(tdo))
    else $error("tdo moved while tck high");
  oe_at_fall_a: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo_oe moved while tck high");
  chain_fast_a: assert property ($rose(part_reset) |-> tck && $past(tdi, 3))
    else $error("reset did not follow shifted one");
  timeout_len_a: assert property ($fell(part_reset) |-> rise_gap_ff >= TOUT0_CYC)
    else $error("reset time-out too short");
  key_update_a: assert property ($changed(prog_mode) |-> tck && $past(tck, 2))
    else $error("programming mode moved off a tck rise");
  exec_idle_a: assert property ($rose(nvm_busy) |-> tck && prog_mode && !$past(tms, 3))
    else $error("execution outside idle or while locked");
  busy_min_a: assert property ($rose(nvm_busy) |-> nvm_busy [*8])
    else $error("busy too short");
  reset_clear_a: assert property ($rose(arst_n) |-> !prog_mode && !nvm_busy)
    else $error("unlock not cleared by reset");
endmodule
bind jnp_engine jnp_monitor #(.TOUT0_CYC(TOUT0_CYC)) jnp_monitor_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
  .clk_opt(clk_opt), .part_reset(part_reset), .prog_mode(prog_mode), .nvm_busy(nvm_busy)
);

// [verif/jnp_prog_model.sv]
`timescale 1ns/1ps
// programmer at the pins; tck stands still outside scans
module jnp_prog_model (
  // clock
  input  wire logic clk_sys,
  // test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // 125 ns period; tms and tdi settle well before the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (6) @(posedge clk_sys);
    o = tdo;
    tck <= 1'b1;
    repeat (12) @(posedge clk_sys);
    tck <= 1'b0;
    repeat (7) @(posedge clk_sys);
  endtask
  // from idle to idle, plus one idle rise that executes a command
  task automatic scan(input logic ir, input logic [15:0] v, input int n, output logic [15:0] r);
    logic o;
    r = 16'h0000;
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, v[i], o);
      r[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic [1:0]  clk_opt = 2'h0;
  logic        tck, tms, tdi, tdo, tdo_oe, part_reset, prog_mode, nvm_busy;
  logic [15:0] res;
  logic [15:0] dat [2] = '{16'h3ca5, 16'hc35a};
  int          tout [4] = '{jnp_pkg::RST_TOUT0_CYC, 220, 240, 260};
  int          err_total = 0;
  int          checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  jnp_engine #(.TOUT1_CYC(220), .TOUT2_CYC(240), .TOUT3_CYC(260),
    .PAGE_WR_CYC(200), .EE_WR_CYC(150)) jnp_engine_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .clk_opt(clk_opt), .part_reset(part_reset), .prog_mode(prog_mode), .nvm_busy(nvm_busy));
  jnp_prog_model jnp_prog_model_inst (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic test_done;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ir(input logic [3:0] c);
    jnp_prog_model_inst.scan(1'b1, {12'h000, c}, 4, res);
  endtask
  task automatic cmd(input logic [14:0] w);
    jnp_prog_model_inst.scan(1'b0, {1'b0, w}, 15, res);
  endtask
  // words are issued in the order written
  task automatic run(input int n, input logic [149:0] w);
    for (int i = 0; i < n; i++) begin
      cmd(w[(n - 1 - i) * 15 +: 15]);
    end
  endtask
  task automatic poll(input logic [14:0] w);
    int k;
    for (k = 0; k < 40; k++) begin
      cmd(w);
      if (res[jnp_pkg::DONE_BIT] === 1'b1) break;
    end
    chk("done flag", 16'(k < 40), 16'h0001);
    if (k == 40) test_done();
  endtask
  task automatic t_chain;
    logic o;
    int   n;
    ir(jnp_pkg::INSTR_PART_RESET);
    for (int c = 0; c < 4; c++) begin
      clk_opt <= 2'(c);
      jnp_prog_model_inst.tick(1'b1, 1'b0, o);
      jnp_prog_model_inst.tick(1'b0, 1'b0, o);
      jnp_prog_model_inst.tick(1'b0, 1'b0, o);
      jnp_prog_model_inst.tick(1'b0, 1'b1, o);
      chk("reset at shift", part_reset, 1'b1);
      repeat (300) @(posedge clk_sys);
      chk("reset held", part_reset, 1'b1);
      jnp_prog_model_inst.tick(1'b1, 1'b0, o);
      for (n = 19; n < 300 && part_reset !== 1'b0; n++) @(posedge clk_sys);
      chk("time-out", 16'(n >= tout[c] + 1 && n <= tout[c] + 8), 16'h0001);
      if (n == 300) test_done();
      jnp_prog_model_inst.tick(1'b1, 1'b0, o);
      jnp_prog_model_inst.tick(1'b0, 1'b0, o);
    end
  endtask
  task automatic t_lock;
    ir(jnp_pkg::INSTR_CMD);
    run(2, {15'h2380, 15'h3180});
    chk("locked busy", nvm_busy, 1'b0);
    ir(jnp_pkg::INSTR_UNLOCK);
    jnp_prog_model_inst.scan(1'b0, jnp_pkg::UNLOCK_SIG ^ 16'h8000, 16, res);
    chk("bad key", prog_mode, 1'b0);
    jnp_prog_model_inst.scan(1'b0, jnp_pkg::UNLOCK_SIG, 16, res);
    chk("good key", prog_mode, 1'b1);
  endtask
  task automatic t_flash;
    ir(jnp_pkg::INSTR_CMD);
    run(2, {15'h2380, 15'h3180});
    chk("erase busy", nvm_busy, 1'b1);
    run(2, {15'h3380, 15'h3380});
    poll(15'h3380);
    run(2, {15'h2310, 15'h0700});
    for (int w = 0; w < 2; w++) begin
      run(6, {7'h03, 8'(5 + w), 7'h13, dat[w][7:0], 7'h17, dat[w][15:8], 15'h3700, 15'h7700, 15'h3700});
    end
    cmd(15'h3500);
    chk("page busy", nvm_busy, 1'b1);
    cmd(15'h3700);
    poll(15'h3700);
    run(6, {15'h2302, 15'h0700, 15'h0305, 15'h3200, 15'h3600, 15'h3700});
    chk("read low", res[7:0], dat[0][7:0]);
    cmd(15'h3700);
    chk("read high", res[7:0], dat[0][15:8]);
    cmd(15'h0305);
    ir(jnp_pkg::INSTR_PAGEREAD);
    for (int b = 0; b < 6; b++) begin
      jnp_prog_model_inst.scan(1'b0, 16'h0000, 8, res);
      chk("page byte", res[7:0], b < 4 ? 8'(dat[b / 2] >> (8 * (b % 2))) : 8'hff);
    end
  endtask
  task automatic t_eeprom;
    ir(jnp_pkg::INSTR_CMD);
    run(7, {15'h2311, 15'h0700, 15'h0302, 15'h1396, 15'h3700, 15'h7700, 15'h3700});
    run(2, {15'h3300, 15'h3100});
    chk("ee busy", nvm_busy, 1'b1);
    cmd(15'h3300);
    poll(15'h3300);
    run(6, {15'h2303, 15'h0700, 15'h0302, 15'h3200, 15'h3300, 15'h3300});
    chk("ee byte", res[7:0], 8'h96);
    ir(jnp_pkg::INSTR_UNLOCK);
    jnp_prog_model_inst.scan(1'b0, jnp_pkg::UNLOCK_RST, 16, res);
    chk("leave mode", prog_mode, 1'b0);
  endtask
  initial begin
    logic o;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk("mode after reset", prog_mode, 1'b0);
    jnp_prog_model_inst.tick(1'b0, 1'b0, o);
    t_chain();
    t_lock();
    t_flash();
    t_eeprom();
    test_done();
  end
endmodule
